// File: verilog/ffc_defines.vh
// constants for the flash fetch cache unit
`ifndef FFC_DEFINES_VH
`define FFC_DEFINES_VH
// register indexes; byte address is four times the index
`define FFC_IDX_READ_TIME     8'hb6
`define FFC_IDX_UNLOCK_KEY    8'hb7
`define FFC_IDX_CACHE_CTRL    8'h84
`define FFC_IDX_CACHE_TUNE    8'hc9
// reset values
`define FFC_RST_READ_TIME     8'h00
`define FFC_RST_CACHE_CTRL    8'he6
`define FFC_RST_CACHE_TUNE    8'h04
// field positions
`define FFC_RSL_LO            4
`define FFC_RSL_HI            5
`define FFC_CC_WREN           7
`define FFC_CC_RDEN           6
`define FFC_CC_PFEN           5
`define FFC_CC_FLUSH          4
`define FFC_CT_REPL_SEL       3
// unlock key codes
`define FFC_KEY_FIRST         8'ha5
`define FFC_KEY_SECOND        8'hf1
// lock states as read back
`define FFC_LK_LOCKED         2'b00
`define FFC_LK_FIRST_OK       2'b01
`define FFC_LK_UNLOCKED       2'b10
`define FFC_LK_DISABLED       2'b11
// read strobe lengths in system clock cycles
`define FFC_STROBE_SHORT      2'd1
`define FFC_STROBE_LONG       2'd2
`endif

// File: verilog/ffc_key_lock.v
// two-step key lock gating flash write and erase
`timescale 1ns/1ps
module ffc_key_lock (
    input  wire       pclk,
    input  wire       presetn,
    input  wire       key_wr,
    input  wire [7:0] key_data,
    input  wire       mod_req,
    input  wire       mod_done,
    output reg  [1:0] lock_state_r,
    output reg        mod_go_r
);
`include "ffc_defines.vh"
    reg [1:0] lock_state_nxt;
    reg       spent_r;

    always @* begin
        lock_state_nxt = lock_state_r;
        if (lock_state_r != `FFC_LK_DISABLED) begin
            if (mod_req && (lock_state_r != `FFC_LK_UNLOCKED || spent_r)) begin
                lock_state_nxt = `FFC_LK_DISABLED;
            end else if (key_wr) begin
                case (lock_state_r)
                    `FFC_LK_LOCKED: begin
                        lock_state_nxt = (key_data == `FFC_KEY_FIRST) ? `FFC_LK_FIRST_OK : `FFC_LK_DISABLED;
                    end
                    `FFC_LK_FIRST_OK: begin
                        lock_state_nxt = (key_data == `FFC_KEY_SECOND) ? `FFC_LK_UNLOCKED : `FFC_LK_DISABLED;
                    end
                    default: begin
                        lock_state_nxt = `FFC_LK_DISABLED;
                    end
                endcase
            end else if (mod_done && lock_state_r == `FFC_LK_UNLOCKED) begin
                lock_state_nxt = `FFC_LK_LOCKED;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_state_r <= `FFC_LK_LOCKED;
            mod_go_r     <= 1'b0;
            spent_r      <= 1'b0;
        end else begin
            lock_state_r <= lock_state_nxt;
            // second attempt before completion is refused
            spent_r      <= (lock_state_nxt == `FFC_LK_UNLOCKED) && (spent_r || mod_req);
            mod_go_r     <= mod_req && (lock_state_r == `FFC_LK_UNLOCKED) && !spent_r;
        end
    end
endmodule

// File: verilog/ffc_repl_ptr.v
// replacement slot pointer, rebound or pseudo-random
`timescale 1ns/1ps
module ffc_repl_ptr (
    input  wire       pclk,
    input  wire       presetn,
    input  wire       advance,
    input  wire       rand_sel,
    output reg  [4:0] ptr_r
);
    reg       down_r;
    reg [4:0] lfsr_r;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_r  <= 5'h00;
            down_r <= 1'b0;
            lfsr_r <= 5'h01;
        end else begin
            lfsr_r <= {lfsr_r[3:0], lfsr_r[4] ^ lfsr_r[2]};
            if (advance) begin
                if (rand_sel) begin
                    ptr_r <= lfsr_r;
                end else if (!down_r) begin
                    if (ptr_r == 5'h1f) begin
                        down_r <= 1'b1;
                        ptr_r  <= 5'h1e;
                    end else begin
                        ptr_r <= ptr_r + 5'h01;
                    end
                end else begin
                    if (ptr_r == 5'h00) begin
                        down_r <= 1'b0;
                        ptr_r  <= 5'h01;
                    end else begin
                        ptr_r <= ptr_r - 5'h01;
                    end
                end
            end
        end
    end
endmodule

// File: verilog/ffc_top.v
// flash fetch front end: key lock, read strobe, prefetch and branch target cache
//
// Summary of operation
// - key register takes 0xA5 then 0xF1 before a flash write or erase
// - one write or erase per unlock, then back to locked
// - wrong key or locked write or erase locks until reset
// - key register reads lock state in bits 1-0
// - each flash read drives a one or two cycle strobe
// - strobe length field sits in bits 5-4, four clock ranges
// - strobe length resets to the slowest clock setting
// - flash active only while strobe high, else low power
// - read-time bits 3-0 and 7-6 read zero
// - 32 slots of 4 bytes beside a 4-byte prefetch engine
// - prefetch reads four bytes at a time for straight code
// - cache hit returns the word without a flash read
// - a miss stalls the core for at most four cycles
// - tag holds 13 upper address bits and valid, word aligned
// - fetch address compared with all tags including linear tag
// - fetch of word being prefetched waits for that read
// - miss abandons prefetch and restarts at requested address
// - fetched miss data goes to the replacement slot, tag valid
// - replacement rebound when select is 0, pseudo-random when 1
// - flush bit written 1 invalidates all entries
// - flash write or erase invalidates affected entries
// - flush bit reads zero
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module ffc_top #(
    parameter SLOTS = 32
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        fetch_req,
    input  wire [14:0] fetch_addr,
    output reg         fetch_valid,
    output reg  [31:0] fetch_data,
    output reg         flash_rd_strobe,
    output reg         flash_low_power,
    output reg  [12:0] flash_word_addr,
    input  wire [31:0] flash_rdata,
    input  wire        flash_mod_req,
    input  wire        flash_mod_erase,
    input  wire [14:0] flash_mod_addr,
    input  wire        flash_mod_done,
    output wire        flash_mod_go
);
`include "ffc_defines.vh"

    // match of a tag against a flash write (word) or erase (1 KB page)
    function mod_hit;
        input [12:0] tag;
        input [14:0] addr;
        input        erase;
        begin
            mod_hit = erase ? (tag[12:8] == addr[14:10]) : (tag == addr[14:2]);
        end
    endfunction

    function apb_sel;
        input [11:0] addr;
        input [7:0]  idx;
        begin
            apb_sel = (addr == {2'b00, idx, 2'b00});
        end
    endfunction

    // registers
    localparam [7:0] RST_RT = `FFC_RST_READ_TIME;
    localparam [7:0] RST_CT = `FFC_RST_CACHE_TUNE;
    reg  [1:0]  rsl_r;
    reg  [7:0]  cc_r;
    reg  [3:0]  ct_r;
    wire [1:0]  lock_state;

    // cache store
    reg  [12:0] tag_mem [0:SLOTS-1];
    reg  [31:0] slot_mem [0:SLOTS-1];
    reg  [SLOTS-1:0] valid_r;
    reg         lin_valid_r;
    reg  [12:0] lin_tag_r;
    reg  [31:0] lin_data_r;

    // flash read engine
    reg         rd_busy_r;
    reg  [1:0]  rd_cnt_r;
    reg  [12:0] rd_tag_r;
    reg         rd_demand_r;

    wire        apb_done = psel && penable && pready;
    wire        wr_done  = apb_done && pwrite;
    wire        key_wr   = wr_done && apb_sel(paddr, `FFC_IDX_UNLOCK_KEY);
    wire        flush    = wr_done && apb_sel(paddr, `FFC_IDX_CACHE_CTRL) && pwdata[`FFC_CC_FLUSH];
    wire        mod_inval = flash_mod_req && (lock_state == `FFC_LK_UNLOCKED);
    wire        cwe      = cc_r[`FFC_CC_WREN];
    wire        crd      = cc_r[`FFC_CC_RDEN];
    wire        pfen     = cc_r[`FFC_CC_PFEN];
    wire [12:0] req_tag  = fetch_addr[14:2];
    wire        take     = fetch_req && !fetch_valid;
    wire        rd_done  = rd_busy_r && (rd_cnt_r == 2'd0);
    wire [1:0]  strobe_len = (rsl_r == 2'b00) ? `FFC_STROBE_SHORT : `FFC_STROBE_LONG;
    wire        lin_hit  = lin_valid_r && (lin_tag_r == req_tag);
    wire        pend_hit = rd_busy_r && (rd_tag_r == req_tag);
    wire [4:0]  repl_ptr;
    reg         c_hit;
    reg  [4:0]  c_idx;
    reg         fill;
    integer     i;
    integer     j;

    // one word ahead only after a read the core waited for
    wire        pf_next   = rd_done && pfen && (rd_demand_r || (take && pend_hit));
    wire        rd_start  = take && !(crd && c_hit) && !lin_hit && !pend_hit;
    wire        rd_active = (rd_busy_r && !rd_done) || pf_next || rd_start;

    // associative compare across all slots
    always @* begin
        c_hit = 1'b0;
        c_idx = 5'h00;
        for (i = 0; i < SLOTS; i = i + 1) begin
            if (valid_r[i] && tag_mem[i] == req_tag) begin
                c_hit = 1'b1;
                c_idx = i[4:0];
            end
        end
    end

    // miss data is cached only when the core waited for it
    always @* begin
        fill = rd_done && rd_demand_r && cwe;
    end

    ffc_key_lock u_key (
        .pclk         (pclk),
        .presetn      (presetn),
        .key_wr       (key_wr),
        .key_data     (pwdata[7:0]),
        .mod_req      (flash_mod_req),
        .mod_done     (flash_mod_done),
        .lock_state_r (lock_state),
        .mod_go_r     (flash_mod_go)
    );

    ffc_repl_ptr u_repl (
        .pclk     (pclk),
        .presetn  (presetn),
        .advance  (fill),
        .rand_sel (ct_r[`FFC_CT_REPL_SEL]),
        .ptr_r    (repl_ptr)
    );

    // apb slave, one access cycle, registered answer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            rsl_r   <= RST_RT[`FFC_RSL_HI:`FFC_RSL_LO];
            cc_r    <= `FFC_RST_CACHE_CTRL & ~(8'h01 << `FFC_CC_FLUSH);
            ct_r    <= RST_CT[3:0];
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable) begin
                if (apb_sel(paddr, `FFC_IDX_READ_TIME)) begin
                    prdata <= {26'h000_0000, rsl_r, 4'h0};
                end else if (apb_sel(paddr, `FFC_IDX_UNLOCK_KEY)) begin
                    prdata <= {30'h0000_0000, lock_state};
                end else if (apb_sel(paddr, `FFC_IDX_CACHE_CTRL)) begin
                    prdata <= {24'h00_0000, cc_r};
                end else if (apb_sel(paddr, `FFC_IDX_CACHE_TUNE)) begin
                    prdata <= {28'h000_0000, ct_r};
                end else begin
                    pslverr <= 1'b1;
                end
            end
            if (wr_done) begin
                if (apb_sel(paddr, `FFC_IDX_READ_TIME)) begin
                    rsl_r <= pwdata[`FFC_RSL_HI:`FFC_RSL_LO];
                end
                if (apb_sel(paddr, `FFC_IDX_CACHE_CTRL)) begin
                    cc_r <= pwdata[7:0] & ~(8'h01 << `FFC_CC_FLUSH);
                end
                if (apb_sel(paddr, `FFC_IDX_CACHE_TUNE)) begin
                    ct_r <= pwdata[3:0];
                end
            end
        end
    end

    // fetch path, flash read engine, linear slot and valid bits
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch_valid     <= 1'b0;
            fetch_data      <= 32'h0000_0000;
            rd_busy_r       <= 1'b0;
            rd_cnt_r        <= 2'd0;
            rd_tag_r        <= 13'h0000;
            rd_demand_r     <= 1'b0;
            lin_valid_r     <= 1'b0;
            lin_tag_r       <= 13'h0000;
            lin_data_r      <= 32'h0000_0000;
            valid_r         <= {SLOTS{1'b0}};
        end else begin
            fetch_valid <= 1'b0;
            if (rd_busy_r && !rd_done) begin
                rd_cnt_r <= rd_cnt_r - 2'd1;
            end
            if (rd_done) begin
                rd_busy_r   <= 1'b0;
                rd_demand_r <= 1'b0;
                lin_valid_r <= 1'b1;
                lin_tag_r   <= rd_tag_r;
                lin_data_r  <= flash_rdata;
                if (fill) begin
                    valid_r[repl_ptr] <= 1'b1;
                end
                if (pf_next) begin
                    // next sequential word into the linear slot
                    rd_busy_r   <= 1'b1;
                    rd_cnt_r    <= strobe_len - 2'd1;
                    rd_tag_r    <= rd_tag_r + 13'h0001;
                    rd_demand_r <= 1'b0;
                end
            end
            if (take) begin
                if (crd && c_hit) begin
                    fetch_valid <= 1'b1;
                    fetch_data  <= slot_mem[c_idx];
                end else if (lin_hit) begin
                    fetch_valid <= 1'b1;
                    fetch_data  <= lin_data_r;
                end else if (pend_hit) begin
                    if (rd_done) begin
                        fetch_valid <= 1'b1;
                        fetch_data  <= flash_rdata;
                    end else begin
                        rd_demand_r <= 1'b1;
                    end
                end else begin
                    // abandon any prefetch and read the wanted word
                    rd_busy_r   <= 1'b1;
                    rd_cnt_r    <= strobe_len - 2'd1;
                    rd_tag_r    <= req_tag;
                    rd_demand_r <= 1'b1;
                end
            end
            if (flush) begin
                valid_r     <= {SLOTS{1'b0}};
                lin_valid_r <= 1'b0;
            end else if (mod_inval) begin
                for (j = 0; j < SLOTS; j = j + 1) begin
                    if (mod_hit(tag_mem[j], flash_mod_addr, flash_mod_erase)) begin
                        valid_r[j] <= 1'b0;
                    end
                end
                if (mod_hit(lin_tag_r, flash_mod_addr, flash_mod_erase)) begin
                    lin_valid_r <= 1'b0;
                end
            end
        end
    end

    // strobe follows the next busy state so flash sleeps between reads
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_rd_strobe <= 1'b0;
            flash_low_power <= 1'b1;
            flash_word_addr <= 13'h0000;
        end else begin
            flash_rd_strobe <= rd_active;
            flash_low_power <= !rd_active;
            if (rd_start) begin
                flash_word_addr <= req_tag;
            end else if (pf_next) begin
                flash_word_addr <= rd_tag_r + 13'h0001;
            end
        end
    end

    // slot and tag storage, written on a cacheable miss
    always @(posedge pclk) begin
        if (fill) begin
            tag_mem[repl_ptr]  <= rd_tag_r;
            slot_mem[repl_ptr] <= flash_rdata;
        end
    end
endmodule

// File: verif/ffc_top_props.sv
// concurrent checks on the ports of the flash fetch front end
`timescale 1ns/1ps
`include "ffc_defines.vh"
module ffc_top_props #(
    parameter SLOTS = 32
) (
    input logic        pclk,
    input logic        presetn,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    input logic        fetch_req,
    input logic [14:0] fetch_addr,
    input logic        fetch_valid,
    input logic [31:0] fetch_data,
    input logic        flash_rd_strobe,
    input logic        flash_low_power,
    input logic [12:0] flash_word_addr,
    input logic [31:0] flash_rdata,
    input logic        flash_mod_req,
    input logic        flash_mod_erase,
    input logic [14:0] flash_mod_addr,
    input logic        flash_mod_done,
    input logic        flash_mod_go
);
    wire rd_ok   = psel && penable && pready && !pwrite;
    wire rd_time = rd_ok && paddr == {2'b00, `FFC_IDX_READ_TIME, 2'b00};
    wire rd_key  = rd_ok && paddr == {2'b00, `FFC_IDX_UNLOCK_KEY, 2'b00};
    wire rd_ctrl = rd_ok && paddr == {2'b00, `FFC_IDX_CACHE_CTRL, 2'b00};
    reg  refused_r;
    // a refused attempt means no further attempt may pass before reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            refused_r <= 1'b0;
        else if ($past(flash_mod_req) && !flash_mod_go)
            refused_r <= 1'b1;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_low_power; flash_low_power == !flash_rd_strobe; endproperty
    property p_strobe_len;
        flash_rd_strobe && $past(flash_rd_strobe) && $stable(flash_word_addr) |=>
            !flash_rd_strobe || $changed(flash_word_addr);
    endproperty
    property p_stall; $rose(fetch_req) |-> ##[1:5] fetch_valid; endproperty
    property p_go_cause; flash_mod_go |-> $past(flash_mod_req); endproperty
    property p_refused; refused_r |-> !flash_mod_go; endproperty
    property p_key_read; rd_key |-> prdata[31:2] == 30'h0; endproperty
    property p_time_read; rd_time |-> prdata[7:6] == 2'b00 && prdata[3:0] == 4'h0; endproperty
    property p_flush_read; rd_ctrl |-> !prdata[`FFC_CC_FLUSH]; endproperty
    a_low_power: assert property (p_low_power) else $error("low power not inverse of strobe");
    a_strobe_len: assert property (p_strobe_len) else $error("strobe longer than two cycles");
    a_stall: assert property (p_stall) else $error("fetch stalled too long");
    a_go_cause: assert property (p_go_cause) else $error("modify go without request");
    a_refused: assert property (p_refused) else $error("modify allowed after lockout");
    a_key_read: assert property (p_key_read) else $error("key read upper bits set");
    a_time_read: assert property (p_time_read) else $error("read time spare bits set");
    a_flush_read: assert property (p_flush_read) else $error("flush bit reads one");
    c_fetch: cover property (fetch_valid);
    c_go: cover property (flash_mod_go);
    c_err: cover property (pslverr && pready);
endmodule
bind ffc_top ffc_top_props #(.SLOTS(SLOTS)) u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_valid(fetch_valid),
    .fetch_data(fetch_data), .flash_rd_strobe(flash_rd_strobe), .flash_low_power(flash_low_power),
    .flash_word_addr(flash_word_addr), .flash_rdata(flash_rdata), .flash_mod_req(flash_mod_req),
    .flash_mod_erase(flash_mod_erase), .flash_mod_addr(flash_mod_addr), .flash_mod_done(flash_mod_done),
    .flash_mod_go(flash_mod_go));

// File: verif/ffc_flash_model.sv
// flash array and programmer model on the far side of the front end
`timescale 1ns/1ps
module ffc_flash_model (
    input  logic        pclk,
    input  logic        presetn,
    input  logic        flash_rd_strobe,
    input  logic [12:0] flash_word_addr,
    input  logic        flash_mod_go,
    output logic [31:0] flash_rdata,
    output logic        flash_mod_done
);
    logic [31:0] word;
    logic [2:0]  busy_cnt_r;
    assign word = {3'b101, flash_word_addr, 3'b010, ~flash_word_addr};
    // data only valid while strobed, lines flip otherwise
    assign flash_rdata = flash_rd_strobe ? word : ~word;
    // programming runs a few cycles, then reports completion
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_cnt_r <= 3'd0;
            flash_mod_done <= 1'b0;
        end else begin
            flash_mod_done <= (busy_cnt_r == 3'd1);
            if (flash_mod_go)
                busy_cnt_r <= 3'd3;
            else if (busy_cnt_r != 3'd0)
                busy_cnt_r <= busy_cnt_r - 3'd1;
        end
    end
endmodule

// File: verif/tb.sv
// self-checking bench for the flash fetch front end
`timescale 1ns/1ps
`include "ffc_defines.vh"
module tb;
    reg         pclk = 1'b0;
    reg         presetn = 1'b0;
    reg         psel = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite = 1'b0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h0000_0000;
    reg         fetch_req = 1'b0;
    reg  [14:0] fetch_addr = 15'h0000;
    reg         flash_mod_req = 1'b0;
    reg         flash_mod_erase = 1'b0;
    reg  [14:0] flash_mod_addr = 15'h0000;
    wire [31:0] prdata, fetch_data, flash_rdata;
    wire        pready, pslverr, fetch_valid, flash_rd_strobe, flash_low_power, flash_mod_done, flash_mod_go;
    wire [12:0] flash_word_addr;
    reg  [31:0] rd_v;
    reg         err_v;
    integer     error_cnt = 0, n_compared = 0, lat, stb, k, i;
    integer     seed = 32'h4000bfd4;
    always #2 pclk = ~pclk;
    ffc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_valid(fetch_valid), .fetch_data(fetch_data),
        .flash_rd_strobe(flash_rd_strobe), .flash_low_power(flash_low_power),
        .flash_word_addr(flash_word_addr), .flash_rdata(flash_rdata), .flash_mod_req(flash_mod_req),
        .flash_mod_erase(flash_mod_erase), .flash_mod_addr(flash_mod_addr),
        .flash_mod_done(flash_mod_done), .flash_mod_go(flash_mod_go));
    ffc_flash_model flash_u (.pclk(pclk), .presetn(presetn), .flash_rd_strobe(flash_rd_strobe),
        .flash_word_addr(flash_word_addr), .flash_mod_go(flash_mod_go), .flash_rdata(flash_rdata),
        .flash_mod_done(flash_mod_done));
    function [31:0] exp_word(input [12:0] w);
        exp_word = {3'b101, w, 3'b010, ~w};
    endfunction
    task test_done;
        begin
            $display("compared %0d mismatches %0d", n_compared, error_cnt);
            if (error_cnt == 0 && n_compared > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task timed_out;
        begin
            error_cnt = error_cnt + 1;
            test_done;
        end
    endtask
    task apb(input wr, input [7:0] idx, input [31:0] wd);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= wr;
            paddr <= {2'b00, idx, 2'b00};
            pwdata <= wd;
            @(posedge pclk);
            penable <= 1'b1;
            i = 0;
            do begin
                @(posedge pclk);
                i = i + 1;
            end while (pready !== 1'b1 && i < 20);
            if (i >= 20)
                timed_out;
            rd_v = prdata;
            err_v = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task rd(input [7:0] idx, input [31:0] exp);
        begin
            apb(1'b0, idx, 32'h0000_0000);
            chk(rd_v, exp);
        end
    endtask
    task fetch(input [14:0] a);
        begin
            @(posedge pclk);
            fetch_req <= 1'b1;
            fetch_addr <= a;
            lat = 0;
            stb = 0;
            do begin
                @(posedge pclk);
                lat = lat + 1;
                stb = stb + (flash_rd_strobe && !fetch_valid);
            end while (fetch_valid !== 1'b1 && lat < 20);
            fetch_req <= 1'b0;
            if (lat >= 20)
                timed_out;
            chk(fetch_data, exp_word(a[14:2]));
            chk(lat <= 5, 1);
        end
    endtask
    task modify(input [14:0] a, input exp_go);
        begin
            @(posedge pclk);
            flash_mod_req <= 1'b1;
            flash_mod_addr <= a;
            flash_mod_erase <= $random(seed);
            @(posedge pclk);
            flash_mod_req <= 1'b0;
            @(posedge pclk);
            chk(flash_mod_go, exp_go);
            repeat (6) @(posedge pclk);
        end
    endtask
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(`FFC_IDX_READ_TIME, `FFC_RST_READ_TIME);
        rd(`FFC_IDX_UNLOCK_KEY, {30'h0, `FFC_LK_LOCKED});
        rd(`FFC_IDX_CACHE_CTRL, `FFC_RST_CACHE_CTRL);
        rd(`FFC_IDX_CACHE_TUNE, `FFC_RST_CACHE_TUNE);
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk(err_v, 1);
        // strobe length per clock range, prefetch and cache parked while the range is written, enabled again before the fetch
        for (k = 3; k >= 0; k = k - 1) begin
            apb(1'b1, `FFC_IDX_CACHE_CTRL, 32'h0000_0006);
            apb(1'b1, `FFC_IDX_READ_TIME, 32'h0000_00c0 | (k << 4));
            apb(1'b1, `FFC_IDX_CACHE_CTRL, 32'h0000_00e6);
            rd(`FFC_IDX_READ_TIME, k << 4);
            repeat (8) @(posedge pclk);
            fetch(15'h1000 + k * 64);
            chk(stb, (k == 0) ? 1 : 2);
        end
        fetch(15'h0200);
        fetch(15'h0201);
        chk(lat, 2);
        repeat (8) @(posedge pclk);
        fetch(15'h0204);
        chk(lat, 2);
        apb(1'b1, `FFC_IDX_CACHE_CTRL, 32'h0000_00f6);
        fetch(15'h0200);
        chk(lat > 2, 1);
        fetch(15'h0300);
        fetch(15'h0300);
        chk(lat, 2);
        apb(1'b1, `FFC_IDX_UNLOCK_KEY, `FFC_KEY_FIRST);
        rd(`FFC_IDX_UNLOCK_KEY, {30'h0, `FFC_LK_FIRST_OK});
        apb(1'b1, `FFC_IDX_UNLOCK_KEY, `FFC_KEY_SECOND);
        rd(`FFC_IDX_UNLOCK_KEY, {30'h0, `FFC_LK_UNLOCKED});
        modify(15'h0301, 1'b1);
        rd(`FFC_IDX_UNLOCK_KEY, {30'h0, `FFC_LK_LOCKED});
        fetch(15'h0300);
        chk(lat > 2, 1);
        modify(15'h0301, 1'b0);
        rd(`FFC_IDX_UNLOCK_KEY, {30'h0, `FFC_LK_DISABLED});
        fetch(15'h0200);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(`FFC_IDX_UNLOCK_KEY, {30'h0, `FFC_LK_LOCKED});
        fetch(15'h0200);
        chk(lat > 2, 1);
        apb(1'b1, `FFC_IDX_UNLOCK_KEY, 32'h0000_0012);
        rd(`FFC_IDX_UNLOCK_KEY, {30'h0, `FFC_LK_DISABLED});
        // random traffic over more words than slots, both replacement modes
        for (k = 0; k < 60; k = k + 1) begin
            if (k == 30) begin
                apb(1'b1, `FFC_IDX_CACHE_TUNE, 32'h0000_000c);
                rd(`FFC_IDX_CACHE_TUNE, 32'h0000_000c);
            end
            fetch($random(seed) & 15'h01ff);
        end
        test_done;
    end
endmodule
